// ---- hw/icc_consts.svh ----
`ifndef ICC_CONSTS_SVH
`define ICC_CONSTS_SVH

// register byte offsets
`define ICC_OFS_CTRL   8'h00
`define ICC_OFS_BUF    8'h04
`define ICC_OFS_ISTAT  8'h08
`define ICC_OFS_IMASK  8'h0C

// control/status field positions
`define ICC_B_HALT     13
`define ICC_B_TSEL     7
`define ICC_B_CPI_HI   6
`define ICC_B_CPI_LO   5
`define ICC_B_OVF      4
`define ICC_B_BNE      3
`define ICC_B_MODE_HI  2

// writable bits of control/status, and reset value
`define ICC_CTRL_WMASK 16'h20E7
`define ICC_CTRL_RST   16'h0000

// capture mode codes
`define ICC_M_OFF      3'h0
`define ICC_M_BOTH     3'h1
`define ICC_M_FALL     3'h2
`define ICC_M_RISE     3'h3
`define ICC_M_DIV4     3'h4
`define ICC_M_DIV16    3'h5
`define ICC_M_UNUSED   3'h6
`define ICC_M_WAKE     3'h7

// prescaler terminal counts
`define ICC_PS4_LAST   4'h3
`define ICC_PS16_LAST  4'hF
`define ICC_PS_ZERO    4'h0
`define ICC_PS_ONE     4'h1

// interrupt status bits
`define ICC_I_CAP      0
`define ICC_I_OVF      1
`define ICC_I_WAKE     2
`define ICC_IRQ_W      3
`define ICC_IRQ_ZERO   3'h0

`endif

// ---- hw/icc_pkg.sv ----
package icc_pkg;
    typedef logic [15:0] icc_word_t;
    typedef logic [31:0] icc_bus_t;
    typedef logic [2:0]  icc_mode_t;
endpackage

// ---- hw/icc_top.sv ----
`timescale 1ns/1ps
`include "icc_consts.svh"
module icc_top #(
    parameter int DEPTH = 4,
    parameter int PTR_W = 2
) (
    input  wire logic              CLOCK,
    input  wire logic              RST_N,
    input  wire logic              HSEL,
    input  wire logic [7:0]        HADDR,
    input  wire logic [1:0]        HTRANS,
    input  wire logic              HWRITE,
    input  wire logic [2:0]        HSIZE,
    input  wire icc_pkg::icc_bus_t HWDATA,
    input  wire logic              HREADY,
    output icc_pkg::icc_bus_t      HRDATA,
    output logic                   HREADYOUT,
    output logic                   HRESP,
    input  wire logic              CAPTURE_INPUT_PIN,
    input  wire icc_pkg::icc_word_t SECOND_TIMER_COUNT,
    input  wire icc_pkg::icc_word_t THIRD_TIMER_COUNT,
    input  wire logic              CPU_IDLE,
    input  wire logic              CPU_SLEEP,
    output logic                   IRQ,
    output logic                   WAKE
);
    import icc_pkg::*;

    logic [15:0]          ctrl_reg;
    icc_mode_t            mode;
    logic                 mode_off;
    logic                 low_power;
    logic                 halted;
    logic                 active;
    logic                 pin_prev_reg;
    logic                 rise;
    logic                 fall;
    logic [3:0]           ps_reg;
    logic                 cap_evt;
    icc_word_t            cap_val;
    icc_word_t            mem [DEPTH];
    logic [PTR_W-1:0]     wp_reg;
    logic [PTR_W-1:0]     rp_reg;
    logic [PTR_W:0]       cnt_reg;
    logic                 full;
    logic                 push;
    logic                 pop;
    icc_word_t            fifo_head;
    logic                 ovf_reg;
    logic [1:0]           cpi_reg;
    logic                 cap_irq_evt;
    logic                 wake_evt;
    logic [`ICC_IRQ_W-1:0] istat_reg;
    logic [`ICC_IRQ_W-1:0] istat_set;
    logic [`ICC_IRQ_W-1:0] istat_clr;
    logic [`ICC_IRQ_W-1:0] imask_reg;
    logic                 sel;
    logic                 wr_pend_reg;
    logic [7:0]           wr_addr_reg;
    logic                 wr_ctrl;
    logic [15:0]          ctrl_view;

    // decoded control fields
    assign mode      = ctrl_reg[`ICC_B_MODE_HI:0];
    assign mode_off  = (mode == `ICC_M_OFF) || (mode == `ICC_M_UNUSED);
    assign low_power = CPU_IDLE | CPU_SLEEP;
    assign halted    = ctrl_reg[`ICC_B_HALT] & CPU_IDLE;
    assign active    = !mode_off && (mode != `ICC_M_WAKE) && !halted;

    // pin is synchronous to CLOCK, so one flop is enough for edges
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= CAPTURE_INPUT_PIN;
        end
    end

    assign rise = CAPTURE_INPUT_PIN & ~pin_prev_reg;
    assign fall = ~CAPTURE_INPUT_PIN & pin_prev_reg;

    // rising-edge prescaler; off mode holds it at zero
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ps_reg <= `ICC_PS_ZERO;
        end else if (mode_off) begin
            ps_reg <= `ICC_PS_ZERO;
        end else if (active && rise) begin
            if (mode == `ICC_M_DIV4 && ps_reg == `ICC_PS4_LAST) begin
                ps_reg <= `ICC_PS_ZERO;
            end else begin
                ps_reg <= ps_reg + `ICC_PS_ONE;
            end
        end
    end

    // qualifying capture event per mode
    always_comb begin
        cap_evt = 1'b0;
        case (mode)
            `ICC_M_BOTH:  cap_evt = rise | fall;
            `ICC_M_FALL:  cap_evt = fall;
            `ICC_M_RISE:  cap_evt = rise;
            `ICC_M_DIV4:  cap_evt = rise && ps_reg == `ICC_PS4_LAST;
            `ICC_M_DIV16: cap_evt = rise && ps_reg == `ICC_PS16_LAST;
            default:      cap_evt = 1'b0;
        endcase
        cap_evt = cap_evt & active;
    end

    // time base choice
    assign cap_val = ctrl_reg[`ICC_B_TSEL] ? SECOND_TIMER_COUNT
                                           : THIRD_TIMER_COUNT;

    // fifo status; full is judged before any same-cycle pop
    assign full      = (cnt_reg == (PTR_W+1)'(DEPTH));
    assign push      = cap_evt & ~full;
    assign fifo_head = mem[rp_reg];

    // capture storage
    always_ff @(posedge CLOCK) begin
        if (push) begin
            mem[wp_reg] <= cap_val;
        end
    end

    // fifo pointers and fill count
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else if (mode_off) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= rp_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    // overflow: only hardware clears it, in off or unused mode; wake mode keeps it
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ovf_reg <= 1'b0;
        end else if (mode_off) begin
            ovf_reg <= 1'b0;
        end else if (cap_evt && full) begin
            ovf_reg <= 1'b1;
        end
    end

    // captures-per-interrupt counter; both-edge mode bypasses it
    assign cap_irq_evt = cap_evt && ((mode == `ICC_M_BOTH) ||
                         (cpi_reg == ctrl_reg[`ICC_B_CPI_HI:`ICC_B_CPI_LO]));

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cpi_reg <= 2'h0;
        end else if (mode_off || mode == `ICC_M_BOTH) begin
            cpi_reg <= 2'h0;
        end else if (cap_evt) begin
            cpi_reg <= cap_irq_evt ? 2'h0 : cpi_reg + 2'h1;
        end
    end

    // wake, while idle or asleep: pin-only in mode 111, or any capture
    assign wake_evt = low_power &&
                      (((mode == `ICC_M_WAKE) && rise) || cap_evt);

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            WAKE <= 1'b0;
        end else begin
            WAKE <= wake_evt;
        end
    end

    // ahb address phase; zero wait states so hreadyout stays high
    assign sel     = HSEL & HTRANS[1] & HREADY;
    assign pop     = sel && !HWRITE && HADDR == `ICC_OFS_BUF &&
                     cnt_reg != '0;
    assign wr_ctrl = wr_pend_reg && wr_addr_reg == `ICC_OFS_CTRL;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            HREADYOUT   <= 1'b1;
            HRESP       <= 1'b0;
        end else begin
            wr_pend_reg <= sel & HWRITE;
            HREADYOUT   <= 1'b1;
            HRESP       <= 1'b0;
            if (sel) begin
                wr_addr_reg <= HADDR;
            end
        end
    end

    // software-writable control fields
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_reg <= `ICC_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= HWDATA[15:0] & `ICC_CTRL_WMASK;
        end
    end

    // control/status as read, flags from hardware state
    always_comb begin
        ctrl_view = ctrl_reg;
        ctrl_view[`ICC_B_OVF] = ovf_reg;
        ctrl_view[`ICC_B_BNE] = (cnt_reg != '0);
    end

    // sticky status: a set in the clear cycle wins
    assign istat_set = {wake_evt, cap_evt & full, cap_irq_evt};
    assign istat_clr = (wr_pend_reg && wr_addr_reg == `ICC_OFS_ISTAT) ?
                       HWDATA[`ICC_IRQ_W-1:0] : `ICC_IRQ_ZERO;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            istat_reg <= `ICC_IRQ_ZERO;
            imask_reg <= `ICC_IRQ_ZERO;
        end else begin
            istat_reg <= (istat_reg & ~istat_clr) | istat_set;
            if (wr_pend_reg && wr_addr_reg == `ICC_OFS_IMASK) begin
                imask_reg <= HWDATA[`ICC_IRQ_W-1:0];
            end
        end
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(istat_reg & imask_reg);
        end
    end

    // read data registered in the address phase, valid in data phase
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            HRDATA <= '0;
        end else if (sel && !HWRITE) begin
            case (HADDR)
                `ICC_OFS_CTRL:  HRDATA <= {16'h0000, ctrl_view};
                `ICC_OFS_BUF:   HRDATA <= {16'h0000,
                                           (cnt_reg != '0) ? fifo_head : 16'h0000};
                `ICC_OFS_ISTAT: HRDATA <= {29'h0, istat_reg};
                `ICC_OFS_IMASK: HRDATA <= {29'h0, imask_reg};
                default:        HRDATA <= '0;
            endcase
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    sequence s_store_third;
        push && !ctrl_reg[`ICC_B_TSEL];
    endsequence

    sequence s_store_second;
        push && ctrl_reg[`ICC_B_TSEL];
    endsequence

    a_store_third: assert property (s_store_third |=>
        mem[$past(wp_reg)] == $past(THIRD_TIMER_COUNT))
        else $error("third timer count not stored");

    a_store_second: assert property (s_store_second |=>
        mem[$past(wp_reg)] == $past(SECOND_TIMER_COUNT))
        else $error("second timer count not stored");

    a_fall_mode: assert property (mode == `ICC_M_FALL && active |->
        cap_evt == fall)
        else $error("falling mode captured wrong edge");

    a_rise_mode: assert property (mode == `ICC_M_RISE && active |->
        cap_evt == rise)
        else $error("rising mode captured wrong edge");

    a_both_irq: assert property (mode == `ICC_M_BOTH && active && fall |=>
        istat_reg[`ICC_I_CAP])
        else $error("both-edge capture gave no interrupt");

    a_div4_gap: assert property (mode == `ICC_M_DIV4 && cap_evt |->
        rise && ps_reg == `ICC_PS4_LAST)
        else $error("div4 captured off the fourth edge");

    a_off_quiet: assert property (mode_off |-> !cap_evt ##1 (cnt_reg == '0 &&
        !ovf_reg))
        else $error("off mode still holds captures");

    a_halt_idle: assert property (ctrl_reg[`ICC_B_HALT] && CPU_IDLE |->
        !cap_evt)
        else $error("capture taken while halted in idle");

    a_full_drop: assert property (cap_evt && full && !pop |=>
        ovf_reg && cnt_reg == $past(cnt_reg))
        else $error("full buffer did not drop capture");

    a_pop_order: assert property (pop |=> HRDATA[15:0] == $past(fifo_head))
        else $error("buffer read out of order");

    a_wake_pin: assert property (mode == `ICC_M_WAKE && CPU_SLEEP && rise |=>
        WAKE ##1 !WAKE || $past(rise))
        else $error("sleep edge did not wake");

    a_irq_level: assert property (|(istat_reg & imask_reg) |=> IRQ)
        else $error("unmasked status did not raise interrupt");

endmodule

// ---- testbench/icc_pin_model.sv ----
`timescale 1ns/1ps
// far-side signal source; the pin rests low between pulses
module icc_pin_model (
    input  wire logic CLOCK,
    output logic      PIN
);
    initial PIN = 1'b0;

    // each pulse is high one cycle, low one cycle; a settle cycle follows
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge CLOCK);
            PIN <= 1'b1;
            @(posedge CLOCK);
            PIN <= 1'b0;
        end
        @(posedge CLOCK);
    endtask
endmodule

// ---- testbench/test_input_capture_channel.sv ----
`timescale 1ns/1ps
`include "icc_consts.svh"
module test_input_capture_channel;
    import icc_pkg::*;
    logic       clock = 1'b0;
    logic       rst_n;
    logic       hsel;
    logic       hwrite;
    logic       idle;
    logic       sleep;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    icc_bus_t   hwdata;
    icc_word_t  sec;
    icc_word_t  thr;
    icc_bus_t   hrdata;
    icc_bus_t   rdata;
    logic       hreadyout;
    logic       hresp;
    logic       irq;
    logic       wake;
    logic       pin;
    int         err_total = 0;
    int         comparisons = 0;
    int         wakes = 0;

    always #5 clock = ~clock;

    // wake is a one-cycle pulse, so it is counted rather than polled
    always @(posedge clock) if (wake === 1'b1) wakes <= wakes + 1;

    icc_top i_icc_top (
        .CLOCK(clock), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .CAPTURE_INPUT_PIN(pin), .SECOND_TIMER_COUNT(sec),
        .THIRD_TIMER_COUNT(thr), .CPU_IDLE(idle), .CPU_SLEEP(sleep),
        .IRQ(irq), .WAKE(wake));

    icc_pin_model i_icc_pin_model (.CLOCK(clock), .PIN(pin));

    task automatic end_sim;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input icc_bus_t seen, input icc_bus_t exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // bounded wait for hready; running out ends the run
    task automatic wait_rdy;
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge clock);
            if (hreadyout === 1'b1) break;
        end
        if (i == 20) begin
            err_total++;
            end_sim;
        end
    endtask

    // one single transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic w, input icc_bus_t d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rdata = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input icc_bus_t d);
        bus(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a);
        bus(a, 1'b0, 32'h0);
    endtask

    function automatic icc_bus_t ctl(input logic h, t, input logic [1:0] c, input icc_mode_t m);
        return {18'h0, h, 5'h0, t, c, 2'h0, m};
    endfunction

    // passing through off first clears buffer and counters
    task automatic set_mode(input icc_bus_t v);
        wr(`ICC_OFS_CTRL, 32'h0);
        wr(`ICC_OFS_CTRL, v);
    endtask

    task automatic flags(input logic [1:0] e);
        rd(`ICC_OFS_CTRL);
        chk("ovf_bne", 32'(rdata[4:3]), 32'(e));
    endtask

    task automatic pop(input icc_word_t e);
        rd(`ICC_OFS_BUF);
        chk("buf", rdata, {16'h0, e});
    endtask

    task automatic setv(input icc_word_t v);
        @(posedge clock);
        sec <= v;
        thr <= ~v;
    endtask

    task automatic t_reset;
        rd(`ICC_OFS_CTRL);
        chk("ctrl", rdata, 32'h0);
        rd(8'h10);
        chk("unmapped", rdata, 32'h0);
        chk("hresp", 32'(hresp), 32'h0);
    endtask

    task automatic t_order;
        int k;
        set_mode(ctl(1'b0, 1'b1, 2'h0, `ICC_M_RISE));
        flags(2'b00);
        for (k = 1; k <= 3; k++) begin
            setv(16'hA000 + 16'(k));
            i_icc_pin_model.pulse(1);
        end
        flags(2'b01);
        for (k = 1; k <= 3; k++) pop(16'hA000 + 16'(k));
        flags(2'b00);
        pop(16'h0000);
        set_mode(ctl(1'b0, 1'b0, 2'h0, `ICC_M_FALL));
        setv(16'h1234);
        i_icc_pin_model.pulse(1);
        pop(16'hEDCB);
        flags(2'b00);
    endtask

    task automatic t_both;
        set_mode(ctl(1'b0, 1'b0, 2'h3, `ICC_M_BOTH));
        wr(`ICC_OFS_ISTAT, 32'h7);
        setv(16'h0BEE);
        i_icc_pin_model.pulse(1);
        rd(`ICC_OFS_ISTAT);
        chk("istat", rdata, 32'h1);
        pop(16'hF411);
        pop(16'hF411);
        flags(2'b00);
        wr(`ICC_OFS_ISTAT, 32'h7);
    endtask

    task automatic t_ovf;
        int k;
        set_mode(ctl(1'b0, 1'b1, 2'h0, `ICC_M_RISE));
        for (k = 1; k <= 5; k++) begin
            setv(16'h0100 + 16'(k));
            i_icc_pin_model.pulse(1);
        end
        flags(2'b11);
        rd(`ICC_OFS_ISTAT);
        chk("istat", rdata, 32'h3);
        for (k = 1; k <= 4; k++) pop(16'h0100 + 16'(k));
        flags(2'b10);
        // writing ones to the flag bits must not touch them
        wr(`ICC_OFS_CTRL, ctl(1'b0, 1'b1, 2'h0, `ICC_M_RISE) | 32'h18);
        flags(2'b10);
        wr(`ICC_OFS_CTRL, 32'h0);
        flags(2'b00);
        wr(`ICC_OFS_ISTAT, 32'h7);
    endtask

    // one pulse short of the divide count takes nothing
    task automatic t_pre;
        int k;
        for (k = 0; k < 2; k++) begin
            set_mode(ctl(1'b0, 1'b0, 2'h0, k ? `ICC_M_DIV16 : `ICC_M_DIV4));
            setv(16'h0055);
            i_icc_pin_model.pulse(k ? 15 : 3);
            flags(2'b00);
            i_icc_pin_model.pulse(1);
            flags(2'b01);
            pop(16'hFFAA);
        end
    endtask

    task automatic t_cpi;
        int c;
        wr(`ICC_OFS_IMASK, 32'h1);
        for (c = 0; c < 4; c++) begin
            set_mode(ctl(1'b0, 1'b0, 2'(c), `ICC_M_RISE));
            wr(`ICC_OFS_ISTAT, 32'h7);
            if (c > 0) begin
                i_icc_pin_model.pulse(c);
                rd(`ICC_OFS_ISTAT);
                chk("istat", rdata, 32'h0);
                chk("irq", 32'(irq), 32'h0);
            end
            i_icc_pin_model.pulse(1);
            rd(`ICC_OFS_ISTAT);
            chk("istat", rdata, 32'h1);
            chk("irq", 32'(irq), 32'h1);
            wr(`ICC_OFS_ISTAT, 32'h1);
            rd(`ICC_OFS_ISTAT);
            chk("irq", 32'(irq), 32'h0);
        end
        wr(`ICC_OFS_IMASK, 32'h0);
    endtask

    task automatic t_wake;
        int w0;
        set_mode(ctl(1'b0, 1'b0, 2'h0, `ICC_M_UNUSED));
        i_icc_pin_model.pulse(1);
        flags(2'b00);
        set_mode(ctl(1'b0, 1'b0, 2'h0, `ICC_M_WAKE));
        w0 = wakes;
        i_icc_pin_model.pulse(1);
        chk("wakes", 32'(wakes - w0), 32'h0);
        @(posedge clock);
        sleep <= 1'b1;
        i_icc_pin_model.pulse(1);
        // the counter updates at the edge the pulse task returns on
        @(posedge clock);
        chk("wakes", 32'(wakes - w0), 32'h1);
        flags(2'b00);
        rd(`ICC_OFS_ISTAT);
        chk("istat", 32'(rdata[2]), 32'h1);
        sleep <= 1'b0;
        wr(`ICC_OFS_ISTAT, 32'h7);
    endtask

    task automatic t_halt;
        set_mode(ctl(1'b1, 1'b0, 2'h0, `ICC_M_RISE));
        @(posedge clock);
        idle <= 1'b1;
        i_icc_pin_model.pulse(1);
        flags(2'b00);
        wr(`ICC_OFS_CTRL, ctl(1'b0, 1'b0, 2'h0, `ICC_M_RISE));
        i_icc_pin_model.pulse(1);
        flags(2'b01);
        idle <= 1'b0;
        set_mode(32'h0);
    endtask

    initial begin
        rst_n  <= 1'b0;
        hsel   <= 1'b0;
        hwrite <= 1'b0;
        idle   <= 1'b0;
        sleep  <= 1'b0;
        haddr  <= 8'h00;
        htrans <= 2'h0;
        hsize  <= 3'h2;
        hwdata <= 32'h0;
        sec    <= 16'h0;
        thr    <= 16'h0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        t_reset;
        t_order;
        t_both;
        t_ovf;
        t_pre;
        t_cpi;
        t_wake;
        t_halt;
        end_sim;
    end
endmodule
